// ---- logic/ext_irq_pkg.sv ----
// ext_irq_pkg: constants, types and helpers of the external pin interrupt unit.
// Assumes a 100 MHz system clock and a 32-bit APB register port.
`default_nettype none

package ext_irq_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int WDT_PERIOD_NS = 1000;
	localparam int WDT_CYCLES    = WDT_PERIOD_NS / CLK_PERIOD_NS;
	localparam int WDT_CNT_W     = 8;
	localparam int WDT_SAMPLES   = 2;
	localparam int STARTUP_NS_0  = 2000;
	localparam int STARTUP_NS_1  = 4000;
	localparam int STARTUP_NS_2  = 8000;
	localparam int STARTUP_NS_3  = 16000;
	localparam int STARTUP_CYC_0 = (STARTUP_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STARTUP_CYC_1 = (STARTUP_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STARTUP_CYC_2 = (STARTUP_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STARTUP_CYC_3 = (STARTUP_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STARTUP_W     = 16;

	// ---------------------------------------------------------------
	// register map and fields
	// ---------------------------------------------------------------
	localparam int         ADDR_W     = 8;
	localparam int         DATA_W     = 32;
	localparam int         NUM_CH     = 2;
	localparam int         SENSE_W    = 2;
	localparam logic [7:0] OFS_SENSE  = 8'h00;
	localparam logic [7:0] OFS_ENABLE = 8'h04;
	localparam logic [7:0] OFS_FLAGS  = 8'h08;
	localparam logic [7:0] OFS_GLOBAL = 8'h0C;
	localparam logic [7:0] OFS_EVSTAT = 8'h10;
	localparam logic [7:0] OFS_EVMASK = 8'h14;
	localparam logic [7:0] OFS_STATE  = 8'h18;
	localparam int         EN_BIT_BASE   = 6;
	localparam int         FLAG_BIT_BASE = 6;
	localparam int         GLOBAL_BIT    = 7;
	localparam int         EV_CH_BASE    = 0;
	localparam int         EV_WAKE       = 2;
	localparam int         EV_WAKE_NOIRQ = 3;
	localparam int         EV_W          = 4;
	localparam int         ST_PIN_BASE   = 0;
	localparam int         ST_IO_RUN     = 2;
	localparam int         ST_WAKE_BUSY  = 3;
	localparam logic [3:0] SENSE_RST     = 4'h0;
	localparam logic [1:0] ENABLE_RST    = 2'h0;
	localparam logic [3:0] EVMASK_RST    = 4'h0;

	typedef enum logic [1:0] {
		SENSE_LOW  = 2'b00,
		SENSE_ANY  = 2'b01,
		SENSE_FALL = 2'b10,
		SENSE_RISE = 2'b11
	} sense_t;

	typedef struct packed {
		sense_t sense;
		logic   enable;
	} chan_cfg_t;

	typedef struct packed {
		logic pin_sync;
		logic pending;
		logic request;
		logic event_hit;
	} chan_stat_t;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic edge_match(input sense_t s, input logic rise, input logic fall);
		case (s)
			SENSE_ANY:  edge_match = rise | fall;
			SENSE_FALL: edge_match = fall;
			SENSE_RISE: edge_match = rise;
			default:    edge_match = 1'b0;
		endcase
	endfunction

	function automatic logic [STARTUP_W-1:0] startup_cycles(input logic [1:0] f);
		case (f)
			2'h0:    startup_cycles = STARTUP_W'(STARTUP_CYC_0);
			2'h1:    startup_cycles = STARTUP_W'(STARTUP_CYC_1);
			2'h2:    startup_cycles = STARTUP_W'(STARTUP_CYC_2);
			default: startup_cycles = STARTUP_W'(STARTUP_CYC_3);
		endcase
	endfunction

endpackage

`default_nettype wire

// ---- logic/ext_irq_channel.sv ----
// ext_irq_channel: one pin channel: synchroniser, edge detector, pending flag.
// Assumes pin_i is asynchronous and cfg_i comes from registers on clk_i.
`timescale 1ns/1ps
`default_nettype none

module ext_irq_channel (
	input  wire logic                   clk_i,
	input  wire logic                   reset_i,
	input  wire logic                   pin_i,
	input  wire ext_irq_pkg::chan_cfg_t cfg_i,
	input  wire logic                   io_clk_run_i,
	input  wire logic                   flag_clr_i,
	output var  ext_irq_pkg::chan_stat_t stat_o
);
	import ext_irq_pkg::*;

	logic sync1_q;
	logic sync2_q;
	logic prev_q;
	logic pending_q;
	logic pending_d;
	wire logic rise;
	wire logic fall;
	wire logic level_mode;
	wire logic hit;

	// ---------------------------------------------------------------
	// synchroniser and edge detection
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		sync1_q <= pin_i;
		sync2_q <= sync1_q;
		prev_q  <= sync2_q;
	end

	assign rise       = sync2_q & ~prev_q;
	assign fall       = ~sync2_q & prev_q;
	assign level_mode = (cfg_i.sense == SENSE_LOW);
	// edges only count while the io clock runs
	assign hit        = io_clk_run_i & edge_match(cfg_i.sense, rise, fall);

	// ---------------------------------------------------------------
	// pending flag: set wins over clear, held clear in level mode
	// ---------------------------------------------------------------
	assign pending_d = level_mode ? 1'b0 : (hit ? 1'b1 : (flag_clr_i ? 1'b0 : pending_q));

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pending_q <= 1'b0;
		end else begin
			pending_q <= pending_d;
		end
	end

	assign stat_o.pin_sync  = sync2_q;
	assign stat_o.pending   = pending_q;
	assign stat_o.request   = level_mode ? ~sync2_q : pending_q;
	assign stat_o.event_hit = hit | (level_mode & cfg_i.enable & fall);

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_level_flag_clear;
		@(posedge clk_i) disable iff (reset_i) level_mode |=> !pending_q;
	endproperty
	a_level_flag_clear: assert property (p_level_flag_clear) else $error("flag set in level mode");

	property p_fall_sets;
		@(posedge clk_i) disable iff (reset_i)
			io_clk_run_i && cfg_i.sense == SENSE_FALL && $fell(sync2_q) && $stable(cfg_i) |=> pending_q;
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("falling edge missed");

	property p_sync_lag;
		@(posedge clk_i) disable iff (reset_i) stat_o.pin_sync == $past(pin_i, 2);
	endproperty
	a_sync_lag: assert property (p_sync_lag) else $error("synchroniser depth wrong");

	property p_no_edge_halted;
		@(posedge clk_i) disable iff (reset_i) !io_clk_run_i && !pending_q |=> !pending_q;
	endproperty
	a_no_edge_halted: assert property (p_no_edge_halted) else $error("edge seen with io clock halted");

	property p_level_req;
		@(posedge clk_i) disable iff (reset_i) level_mode && !sync2_q |-> stat_o.request;
	endproperty
	a_level_req: assert property (p_level_req) else $error("low level not requesting");

endmodule

`default_nettype wire

// ---- logic/ext_irq_wake.sv ----
// ext_irq_wake: power-down level wake qualifier on a watchdog-rate sample tick.
// Assumes level_low_i is already synchronised to clk_i.
`timescale 1ns/1ps
`default_nettype none

module ext_irq_wake (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       arm_i,
	input  wire logic       level_low_i,
	input  wire logic [1:0] fuses_i,
	output logic            wake_o,
	output logic            irq_ok_o,
	output logic            busy_o
);
	import ext_irq_pkg::*;

	typedef enum logic [1:0] {
		WK_IDLE = 2'b01,
		WK_RUN  = 2'b10
	} wake_state_t;

	wake_state_t              state_q;
	wake_state_t              state_d;
	logic [WDT_CNT_W-1:0]     tick_cnt_q;
	logic [1:0]               hits_q;
	logic [STARTUP_W-1:0]     su_cnt_q;
	wire logic                run;
	wire logic                tick;
	wire logic                qualified;
	wire logic                done;

	assign run       = (state_q == WK_RUN);
	assign tick      = run & (tick_cnt_q == WDT_CNT_W'(WDT_CYCLES - 1));
	assign qualified = (hits_q == 2'(WDT_SAMPLES));
	assign done      = run & (su_cnt_q == '0);

	always_comb begin
		case (state_q)
			WK_IDLE: state_d = (arm_i & level_low_i) ? WK_RUN : WK_IDLE;
			WK_RUN:  state_d = (!arm_i || done) ? WK_IDLE : WK_RUN;
			default: state_d = WK_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_q    <= WK_IDLE;
			tick_cnt_q <= '0;
			hits_q     <= '0;
			su_cnt_q   <= '0;
			wake_o     <= 1'b0;
			irq_ok_o   <= 1'b0;
		end else begin
			state_q    <= state_d;
			tick_cnt_q <= (!run || tick) ? '0 : tick_cnt_q + 1'b1;
			if (!run) begin
				hits_q   <= '0;
				su_cnt_q <= startup_cycles(fuses_i);
			end else begin
				su_cnt_q <= su_cnt_q - 1'b1;
				if (tick && !qualified) begin
					hits_q <= level_low_i ? hits_q + 1'b1 : '0;
				end
			end
			wake_o   <= done & arm_i & (qualified | level_low_i);
			irq_ok_o <= done & level_low_i;
		end
	end

	assign busy_o = run;

endmodule

`default_nettype wire

// ---- logic/ext_irq_unit.sv ----
// ext_irq_unit: two-channel external pin interrupt unit with APB registers.
// Assumes an APB master on clk_i, a power manager driving the sleep inputs,
// and the processor acknowledging vectored requests on irq_ack_i.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - enabled channels trigger from pin activity even when the pin is an output.
// - each channel triggers on falling edge, rising edge or low level.
// - in level mode the request stays high while the pin stays low.
// - edge detection runs on the io clock; no edges while it is halted.
// - low-level detection works without a clock, waking from deep sleep.
// - io clock stops in every sleep mode but idle, so edges cannot wake.
// - power-down level wake samples the level twice at watchdog rate.
// - wake if both samples show the level or it holds through start-up.
// - start-up length comes from the start-up time fuses.
// - level gone before start-up end still wakes but raises no interrupt.
// - two-bit sense field per channel: low, any, fall, rise; ch1 3:2.
// - pin is synchronised before edge detection; pulses over a clock count.
// - edge events set a pending flag, cleared by vectoring or writing one.
// - requests reach the processor only with channel and global enables set.
module ext_irq_unit (
	input  wire logic                             clk_i,
	input  wire logic                             reset_i,
	input  wire logic [ext_irq_pkg::ADDR_W-1:0]   paddr_i,
	input  wire logic                             psel_i,
	input  wire logic                             penable_i,
	input  wire logic                             pwrite_i,
	input  wire logic [ext_irq_pkg::DATA_W-1:0]   pwdata_i,
	output logic      [ext_irq_pkg::DATA_W-1:0]   prdata_o,
	output logic                                  pready_o,
	output logic                                  pslverr_o,
	input  wire logic                             ext_irq_pin_zero_i,
	input  wire logic                             ext_irq_pin_one_i,
	input  wire logic [ext_irq_pkg::NUM_CH-1:0]   irq_ack_i,
	input  wire logic                             sleep_i,
	input  wire logic                             sleep_idle_i,
	input  wire logic [1:0]                       startup_time_fuses_i,
	output logic      [ext_irq_pkg::NUM_CH-1:0]   irq_req_o,
	output logic                                  level_wake_o,
	output logic                                  wake_o,
	output logic                                  irq_o
);
	import ext_irq_pkg::*;

	// ---------------------------------------------------------------
	// registers and wires
	// ---------------------------------------------------------------
	logic [NUM_CH*SENSE_W-1:0] mcu_control_reg_q;
	logic [NUM_CH-1:0]         general_irq_control_reg_q;
	logic                      cpu_status_reg_q;
	logic [EV_W-1:0]           evmask_q;
	logic [EV_W-1:0]           evstat_q;
	logic [EV_W-1:0]           evstat_d;
	logic [DATA_W-1:0]         prdata_q;
	chan_cfg_t                 ch_cfg    [NUM_CH];
	chan_stat_t                ch_stat   [NUM_CH];
	wire logic [NUM_CH-1:0]    pins;
	wire logic [NUM_CH-1:0]    pend;
	wire logic [NUM_CH-1:0]    pin_sync;
	wire logic [NUM_CH-1:0]    ch_event;
	wire logic [NUM_CH-1:0]    level_sel;
	wire logic [NUM_CH-1:0]    flag_clr;
	wire logic                 setup_ph;
	wire logic                 access_ph;
	wire logic                 wr_en;
	wire logic                 rd_access;
	wire logic                 sel_sense;
	wire logic                 sel_enable;
	wire logic                 sel_flags;
	wire logic                 sel_global;
	wire logic                 sel_evstat;
	wire logic                 sel_evmask;
	wire logic                 sel_state;
	wire logic                 mapped;
	wire logic [DATA_W-1:0]    rd_word;
	wire logic [EV_W-1:0]      ev_set;
	wire logic [EV_W-1:0]      ev_rd_clr;
	wire logic                 io_clk_run;
	wire logic                 deep_sleep;
	wire logic                 level_low_sync;
	wire logic                 wake_pulse;
	wire logic                 wake_irq_ok;
	wire logic                 wake_busy;

	// ---------------------------------------------------------------
	// sleep and clock gating view
	// ---------------------------------------------------------------
	assign io_clk_run = ~sleep_i | sleep_idle_i;
	assign deep_sleep = sleep_i & ~sleep_idle_i;

	// pad levels are observed whatever the pin direction
	assign pins = {ext_irq_pin_one_i, ext_irq_pin_zero_i};

	// ---------------------------------------------------------------
	// channels
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			assign ch_cfg[gi].sense  = sense_t'(mcu_control_reg_q[gi*SENSE_W +: SENSE_W]);
			assign ch_cfg[gi].enable = general_irq_control_reg_q[gi];
			assign flag_clr[gi]      = irq_ack_i[gi] | (wr_en & sel_flags & pwdata_i[FLAG_BIT_BASE + gi]);
			assign pend[gi]          = ch_stat[gi].pending;
			assign pin_sync[gi]      = ch_stat[gi].pin_sync;
			assign ch_event[gi]      = ch_stat[gi].event_hit;
			assign level_sel[gi]     = ch_cfg[gi].enable & (ch_cfg[gi].sense == SENSE_LOW);
			assign irq_req_o[gi]     = ch_stat[gi].request & ch_cfg[gi].enable & cpu_status_reg_q;

			ext_irq_channel u_ch (
				.clk_i        (clk_i),
				.reset_i      (reset_i),
				.pin_i        (pins[gi]),
				.cfg_i        (ch_cfg[gi]),
				.io_clk_run_i (io_clk_run),
				.flag_clr_i   (flag_clr[gi]),
				.stat_o       (ch_stat[gi])
			);
		end
	endgenerate

	// clockless low-level path toward the power manager
	assign level_wake_o   = |(level_sel & ~pins);
	assign level_low_sync = |(level_sel & ~pin_sync);

	// ---------------------------------------------------------------
	// power-down wake qualification
	// ---------------------------------------------------------------
	ext_irq_wake u_wake (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.arm_i       (deep_sleep),
		.level_low_i (level_low_sync),
		.fuses_i     (startup_time_fuses_i),
		.wake_o      (wake_pulse),
		.irq_ok_o    (wake_irq_ok),
		.busy_o      (wake_busy)
	);

	assign wake_o = wake_pulse;

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	assign setup_ph   = psel_i & ~penable_i;
	assign access_ph  = psel_i & penable_i;
	assign wr_en      = access_ph & pwrite_i;
	assign rd_access  = access_ph & ~pwrite_i;
	assign sel_sense  = (paddr_i == OFS_SENSE);
	assign sel_enable = (paddr_i == OFS_ENABLE);
	assign sel_flags  = (paddr_i == OFS_FLAGS);
	assign sel_global = (paddr_i == OFS_GLOBAL);
	assign sel_evstat = (paddr_i == OFS_EVSTAT);
	assign sel_evmask = (paddr_i == OFS_EVMASK);
	assign sel_state  = (paddr_i == OFS_STATE);
	assign mapped     = sel_sense | sel_enable | sel_flags | sel_global | sel_evstat | sel_evmask | sel_state;

	assign rd_word = sel_sense  ? DATA_W'(mcu_control_reg_q) :
	                 sel_enable ? DATA_W'(general_irq_control_reg_q) << EN_BIT_BASE :
	                 sel_flags  ? DATA_W'(pend) << FLAG_BIT_BASE :
	                 sel_global ? DATA_W'(cpu_status_reg_q) << GLOBAL_BIT :
	                 sel_evstat ? DATA_W'(evstat_q) :
	                 sel_evmask ? DATA_W'(evmask_q) :
	                 sel_state  ? (DATA_W'(pin_sync) << ST_PIN_BASE) | (DATA_W'(io_clk_run) << ST_IO_RUN) |
	                              (DATA_W'(wake_busy) << ST_WAKE_BUSY) :
	                 '0;

	assign pready_o  = 1'b1;
	assign pslverr_o = access_ph & ~mapped;
	assign prdata_o  = prdata_q;

	// ---------------------------------------------------------------
	// event status: read clears only what the read reported
	// ---------------------------------------------------------------
	assign ev_set    = {wake_pulse & ~wake_irq_ok, wake_pulse, ch_event};
	assign ev_rd_clr = (rd_access & sel_evstat) ? prdata_q[EV_W-1:0] : '0;
	assign evstat_d  = (evstat_q & ~ev_rd_clr) | ev_set;
	assign irq_o     = |(evstat_q & evmask_q);

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mcu_control_reg_q         <= SENSE_RST;
			general_irq_control_reg_q <= ENABLE_RST;
			cpu_status_reg_q          <= 1'b0;
			evmask_q                  <= EVMASK_RST;
			evstat_q                  <= '0;
			prdata_q                  <= '0;
		end else begin
			evstat_q <= evstat_d;
			if (setup_ph && !pwrite_i) begin
				prdata_q <= rd_word;
			end
			if (wr_en && sel_sense) begin
				mcu_control_reg_q <= pwdata_i[NUM_CH*SENSE_W-1:0];
			end
			if (wr_en && sel_enable) begin
				general_irq_control_reg_q <= pwdata_i[EN_BIT_BASE +: NUM_CH];
			end
			if (wr_en && sel_global) begin
				cpu_status_reg_q <= pwdata_i[GLOBAL_BIT];
			end
			if (wr_en && sel_evmask) begin
				evmask_q <= pwdata_i[EV_W-1:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_req_gate;
		@(posedge clk_i) disable iff (reset_i)
			|irq_req_o |-> cpu_status_reg_q && ((irq_req_o & ~general_irq_control_reg_q) == '0);
	endproperty
	a_req_gate: assert property (p_req_gate) else $error("request passed a disabled gate");

	property p_ack_clears;
		@(posedge clk_i) disable iff (reset_i)
			irq_ack_i[0] && !ch_event[0] |=> !pend[0];
	endproperty
	a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear flag");

	property p_w1c_flag;
		@(posedge clk_i) disable iff (reset_i)
			wr_en && sel_flags && pwdata_i[FLAG_BIT_BASE] && !ch_event[0] |=> !pend[0];
	endproperty
	a_w1c_flag: assert property (p_w1c_flag) else $error("write one did not clear flag");

	property p_wake_noirq;
		@(posedge clk_i) disable iff (reset_i)
			wake_pulse && !wake_irq_ok |=> evstat_q[EV_WAKE_NOIRQ] && evstat_q[EV_WAKE];
	endproperty
	a_wake_noirq: assert property (p_wake_noirq) else $error("silent wake not reported");

	property p_wake_needs_deep;
		@(posedge clk_i) disable iff (reset_i)
			$rose(wake_busy) |-> $past(deep_sleep) && $past(level_low_sync);
	endproperty
	a_wake_needs_deep: assert property (p_wake_needs_deep) else $error("wake armed outside deep sleep");

	property p_level_req_ch1;
		@(posedge clk_i) disable iff (reset_i)
			level_sel[1] && cpu_status_reg_q && !pin_sync[1] |-> irq_req_o[1];
	endproperty
	a_level_req_ch1: assert property (p_level_req_ch1) else $error("level request dropped");

	// ---------------------------------------------------------------
	// sleep, wake and event status checks
	// ---------------------------------------------------------------
	property p_idle_runs;
		@(posedge clk_i) disable iff (reset_i)
			sleep_i && sleep_idle_i |-> io_clk_run;
	endproperty
	a_idle_runs: assert property (p_idle_runs) else $error("io clock halted in idle");

	property p_deep_halts;
		@(posedge clk_i) disable iff (reset_i)
			deep_sleep |-> !io_clk_run;
	endproperty
	a_deep_halts: assert property (p_deep_halts) else $error("io clock running in deep sleep");

	property p_level_wake_pin;
		@(posedge clk_i) disable iff (reset_i)
			level_sel[1] && !pins[1] |-> level_wake_o;
	endproperty
	a_level_wake_pin: assert property (p_level_wake_pin) else $error("low level gives no wake");

	// a wake is a single-cycle pulse
	property p_wake_single;
		@(posedge clk_i) disable iff (reset_i)
			wake_pulse |=> !wake_pulse;
	endproperty
	a_wake_single: assert property (p_wake_single) else $error("wake pulse too long");

	// event bits stay until a read reports them
	property p_wake_sticky;
		@(posedge clk_i) disable iff (reset_i)
			evstat_q[EV_WAKE] && !(rd_access && sel_evstat) |=> evstat_q[EV_WAKE];
	endproperty
	a_wake_sticky: assert property (p_wake_sticky) else $error("wake event lost");

	property p_flag_event;
		@(posedge clk_i) disable iff (reset_i)
			$rose(pend[0]) |-> evstat_q[EV_CH_BASE];
	endproperty
	a_flag_event: assert property (p_flag_event) else $error("flag set without event");

	property p_level_event;
		@(posedge clk_i) disable iff (reset_i)
			level_sel[1] && $fell(pin_sync[1]) |=> evstat_q[EV_CH_BASE + 1];
	endproperty
	a_level_event: assert property (p_level_event) else $error("level event missed");

	// main scenarios; the bench reaches all but c_edge_req, as ch1 stays in level mode
	c_idle_edge: cover property (@(posedge clk_i) disable iff (reset_i) sleep_idle_i && $rose(pend[0]));
	c_edge_req: cover property (@(posedge clk_i) disable iff (reset_i) $rose(pend[1]) ##1 irq_req_o[1]);
	c_wake_irq: cover property (@(posedge clk_i) disable iff (reset_i) wake_pulse && wake_irq_ok);
	c_wake_silent: cover property (@(posedge clk_i) disable iff (reset_i) wake_pulse && !wake_irq_ok);
	c_irq_out: cover property (@(posedge clk_i) disable iff (reset_i) $rose(irq_o));

endmodule

`default_nettype wire

// ---- tb/ext_irq_pin_src.sv ----
// ext_irq_pin_src: model of the outside sources that drive both interrupt pins.
// Assumes the bench sets target levels on clk_i; the pins follow one edge later.
`timescale 1ns/1ps
`default_nettype none

module ext_irq_pin_src (
	input  wire logic       clk_i,
	input  wire logic [1:0] level_i,
	output logic            pin_zero_o,
	output logic            pin_one_o
);
	// a source holds its level until told otherwise, through a wake too
	always_ff @(posedge clk_i) begin
		pin_zero_o <= level_i[0];
		pin_one_o  <= level_i[1];
	end
endmodule

`default_nettype wire

// ---- tb/external_pin_interrupt_unit_tb_top.sv ----
// external_pin_interrupt_unit_tb_top: self-checking bench of the pin interrupt unit.
// Assumes ext_irq_pkg, ext_irq_unit and ext_irq_pin_src are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module external_pin_interrupt_unit_tb_top;
	import ext_irq_pkg::*;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [7:0]  paddr_i = 8'h00;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [31:0] pwdata_i = 32'h0;
	logic [1:0]  irq_ack_i = 2'h0;
	logic        sleep_i = 1'b0;
	logic        idle = 1'b0;
	logic [1:0]  fuses = 2'h0;
	logic [1:0]  level = 2'h3;
	logic [31:0] prdata_o;
	logic [1:0]  irq_req_o;
	logic        pready_o, pslverr_o, pin_zero, pin_one, level_wake_o, wake_o, irq_o;
	int          mismatches = 0;
	int          compares = 0;

	always #5 clk_i = ~clk_i;

	ext_irq_pin_src i_ext_irq_pin_src (.clk_i(clk_i), .level_i(level), .pin_zero_o(pin_zero), .pin_one_o(pin_one));

	ext_irq_unit i_ext_irq_unit (.clk_i(clk_i), .reset_i(reset_i), .paddr_i(paddr_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .ext_irq_pin_zero_i(pin_zero), .ext_irq_pin_one_i(pin_one),
		.irq_ack_i(irq_ack_i), .sleep_i(sleep_i), .sleep_idle_i(idle), .startup_time_fuses_i(fuses),
		.irq_req_o(irq_req_o), .level_wake_o(level_wake_o), .wake_o(wake_o), .irq_o(irq_o));

	task automatic end_sim();
		$display("counts: compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		n = 0;
		psel_i <= 1'b1;
		paddr_i <= a;
		pwrite_i <= wr;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (pready_o !== 1'b1) begin
			mismatches++;
			end_sim();
		end
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		`CHK(nm, x, r)
	endtask

	// which 0/1 waits on a channel request, 2 on the wake pulse
	task automatic waitfor(input int which, input int lim, output int n);
		logic s;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
			s = (which < 2) ? irq_req_o[which] : wake_o;
		end while (s !== 1'b1 && n < lim);
		if (s !== 1'b1) begin
			$display("MISMATCH wait %0d exp 1 got %b", which, s);
			mismatches++;
			end_sim();
		end
	endtask

	initial begin
		int          n;
		int          su;
		logic [31:0] r;
		logic        e;
		logic [1:0]  pre;
		cyc(3);
		reset_i <= 1'b0;
		@(posedge clk_i);
		rc("sense", OFS_SENSE, 32'h0);
		rc("enable", OFS_ENABLE, 32'h0);
		apb(1'b0, 8'h1C, 32'h0, r, e);
		`CHK("unmapped err", 1'b1, e)
		`CHK("unmapped data", 32'h0, r)
		$display("test reset done");
		w(OFS_ENABLE, 32'hC0);
		w(OFS_GLOBAL, 32'h80);
		w(OFS_EVMASK, 32'h1);
		for (int s = 1; s < 4; s++) begin
			pre = (s == 3) ? 2'b10 : 2'b11;
			level <= pre;
			cyc(6);
			w(OFS_SENSE, 32'(s));
			w(OFS_FLAGS, 32'h40);
			apb(1'b0, OFS_EVSTAT, 32'h0, r, e);
			level <= {pre[1], ~pre[0]};
			waitfor(0, 20, n);
			`CHK("edge latency", 1'b1, n >= 4 && n <= 6)
			`CHK("irq line", 1'b1, irq_o)
			rc("flag set", OFS_FLAGS, 32'h40);
			rc("event", OFS_EVSTAT, 32'h1);
			`CHK("irq cleared", 1'b0, irq_o)
			w(OFS_FLAGS, 32'h40);
			`CHK("w1c req", 2'b00, irq_req_o)
		end
		$display("test edge modes done");
		w(OFS_GLOBAL, 32'h0);
		level <= 2'b10;
		cyc(8);
		level <= 2'b11;
		cyc(8);
		`CHK("gated req", 2'b00, irq_req_o)
		rc("flag kept", OFS_FLAGS, 32'h40);
		irq_ack_i <= 2'b01;
		@(posedge clk_i);
		irq_ack_i <= 2'b00;
		rc("acked", OFS_FLAGS, 32'h0);
		w(OFS_GLOBAL, 32'h80);
		apb(1'b0, OFS_EVSTAT, 32'h0, r, e);
		$display("test gating done");
		level <= 2'b01;
		waitfor(1, 20, n);
		cyc(50);
		`CHK("level held", 1'b1, irq_req_o[1])
		rc("level flag", OFS_FLAGS, 32'h0);
		rc("level event", OFS_EVSTAT, 32'h2);
		level <= 2'b11;
		cyc(5);
		`CHK("level gone", 1'b0, irq_req_o[1])
		$display("test level done");
		sleep_i <= 1'b1;
		for (int d = 0; d < 2; d++) begin
			idle <= (d == 0);
			level <= 2'b10;
			cyc(8);
			level <= 2'b11;
			cyc(8);
			rc("sleep edge", OFS_FLAGS, (d == 0) ? 32'h40 : 32'h0);
			w(OFS_FLAGS, 32'h40);
			apb(1'b0, OFS_EVSTAT, 32'h0, r, e);
		end
		rc("state", OFS_STATE, 32'h3);
		for (int f = 0; f < 2; f++) begin
			su = f ? STARTUP_CYC_1 - 252 : STARTUP_CYC_0 - 2;
			fuses <= 2'(f);
			level <= 2'b01;
			cyc(2);
			`CHK("clockless wake", 1'b1, level_wake_o)
			if (f == 1) begin
				cyc(250);
				level <= 2'b11;
			end
			waitfor(2, 1000, n);
			`CHK("startup", 1'b1, n >= su && n <= su + 12)
			rc("wake event", OFS_EVSTAT, f ? 32'hE : 32'h6);
			sleep_i <= 1'b0;
			level <= 2'b11;
			cyc(10);
			sleep_i <= 1'b1;
		end
		$display("test wake done");
		end_sim();
	end
endmodule

`default_nettype wire
